// [pkg/timer_ch34_cfg.svh]
`ifndef TIMER_CH34_CFG_SVH
`define TIMER_CH34_CFG_SVH
// Purpose: offsets, field positions and reset values of the block
// Assumes: byte addresses on a classic 32-bit bus, data in bits 15:0
// Notes:   field positions follow the break and dead-time layout
//
// Function
// - output channel drives counter compare result
// - no preload writes active, else at update
// - input channel holds last captured counter
// - value registers read-only in input mode
// - active break clears main output enable
// - main enable gates compare and complementary outputs
// - auto enable sets main enable at update
// - polarity bit selects active break level
// - break enable gates pin and clock failure
// - polarity and enable act one cycle late
// - run off-state keeps inactive outputs enabled
// - no complementary outputs, no run off-state bit
// - lock level writable once until reset
// - idle off-state applies while main enable low
// - dead time decoded from dead-time setting

`define ADR_CH3      8'h3c
`define ADR_CH4      8'h40
`define ADR_BKDT     8'h44

`define BK_MOE       15
`define BK_AOE       14
`define BK_POL       13
`define BK_EN        12
`define BK_RUN_OFFSTATE_SEL      11
`define BK_IDLE_OFFSTATE_SEL      10
`define BK_LCK_HI    9
`define BK_LCK_LO    8
`define BK_DT_HI     7
`define BK_DT_LO     0

`define CH_RESET     16'h0000
`define BKDT_RESET   16'h0000

`endif

// [pkg/timer_ch34_pkg.sv]
// Purpose: types shared by the channel 3/4 and break block
// Assumes: nothing beyond the cfg header
// Notes:   register image matches the 16-bit register layout
package timer_ch34_pkg;

    typedef struct packed {
        logic       moe;
        logic       aoe;
        logic       pol;
        logic       brk_en;
        logic       run_offstate_sel;
        logic       idle_offstate_sel;
        logic [1:0] lock_level;
        logic [7:0] deadtime_setting;
    } bkdt_t;

    typedef struct packed {
        logic        is_input;
        logic        preload;
        logic        update;
        logic        capture;
        logic        wr;
        logic [15:0] wdata;
        logic [15:0] cnt;
    } chan_in_t;

    typedef struct packed {
        logic [15:0] value;
        logic [15:0] active;
        logic        cmp;
    } chan_st_t;

    typedef struct packed {
        bkdt_t       bk;
        logic        pol_eff;
        logic        en_eff;
        logic        lock_done;
        logic        ack;
        logic [31:0] rdat;
        logic [1:0]  oc;
        logic [1:0]  oc_en;
        logic [1:0]  ocn_en;
        logic        break_pin;
        logic [9:0]  dt_ticks;
    } top_st_t;

endpackage : timer_ch34_pkg

// [rtl/ch34_value_unit.sv]
// Purpose: value register, active compare and capture of one channel
// Assumes: write strobe already decoded and lane-merged
// Notes:   compare result is high while counter is below active value
`include "timer_ch34_cfg.svh"
module ch34_value_unit
    import timer_ch34_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // channel controls
    input  wire chan_in_t    ctl_i,
    // results
    output logic [15:0]      value_o,
    output logic             cmp_o
);

    chan_st_t st_q;
    chan_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (ctl_i.is_input) begin
            if (ctl_i.capture) begin
                st_d.value = ctl_i.cnt;
            end
        end else if (ctl_i.wr) begin
            st_d.value = ctl_i.wdata;
            if (!ctl_i.preload) begin
                st_d.active = ctl_i.wdata;
            end
        end
        if (!ctl_i.is_input && ctl_i.preload && ctl_i.update) begin
            st_d.active = st_d.value;
        end
        st_d.cmp = !ctl_i.is_input && (ctl_i.cnt < st_q.active);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '{value: `CH_RESET, active: `CH_RESET, cmp: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign value_o = st_q.value;
    assign cmp_o   = st_q.cmp;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_capture_latch: assert property (
        ctl_i.is_input && ctl_i.capture |=> value_o == $past(ctl_i.cnt))
        else $error("capture did not latch counter");
    a_input_readonly: assert property (
        ctl_i.is_input && !ctl_i.capture |=> $stable(value_o))
        else $error("value changed in input mode");
    a_direct_write: assert property (
        !ctl_i.is_input && ctl_i.wr && !ctl_i.preload
        |=> st_q.active == $past(ctl_i.wdata))
        else $error("direct write missed active value");
    a_preload_hold: assert property (
        !ctl_i.is_input && ctl_i.preload && !ctl_i.update
        |=> $stable(st_q.active))
        else $error("active changed without update");
    a_compare_out: assert property (
        !ctl_i.is_input |=> cmp_o == ($past(ctl_i.cnt) < $past(st_q.active)))
        else $error("compare result wrong");

    c_capture: cover property (ctl_i.is_input && ctl_i.capture);
    c_preload_upd: cover property (ctl_i.preload && ctl_i.update && ctl_i.wr);

endmodule : ch34_value_unit

// [rtl/timer_ch34_break.sv]
// Purpose: channel 3/4 value registers and break/dead-time control
// Assumes: counter, update, mode and enable bits come from the timer core
// Notes:   break acts at the next clock edge; outputs are registered
//
// Register access over Wishbone is this design's own decision.
`include "timer_ch34_cfg.svh"
module timer_ch34_break
    import timer_ch34_pkg::*;
#(
    parameter bit HAS_COMPL = 1'b1
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // timer core
    input  wire logic [15:0] timer_counter_value_i,
    input  wire logic        update_evt_i,
    input  wire logic [1:0]  ch_is_input_i,
    input  wire logic [1:0]  ch_preload_en_i,
    input  wire logic [1:0]  ch_capture_event_i,
    input  wire logic [1:0]  channel_out_en_i,
    input  wire logic [1:0]  channel_compl_out_en_i,
    // break sources
    input  wire logic        break_pin_i,
    input  wire logic        clock_security_fail_i,
    // power stage
    output logic [1:0]       ch_compare_out_o,
    output logic [1:0]       out_en_o,
    output logic [1:0]       compl_out_en_o,
    output logic             main_output_en_o,
    output logic             break_active_o,
    output logic [9:0]       deadtime_ticks_o
);

    top_st_t     st_q;
    top_st_t     st_d;
    chan_in_t    ch_ctl [2];
    logic [15:0] ch_value [2];
    logic [1:0]  ch_cmp;

    logic        access;
    logic        wr;
    logic        wr_lo;
    logic        wr_hi;
    logic        sel_ch3;
    logic        sel_ch4;
    logic        sel_bk;
    logic        brk_raw;
    logic        bk_wr_hi;
    logic        bk_wr_lo;
    logic        ce;
    logic        cn;
    logic        off_en;
    logic [15:0] wmerge [2];

    assign access  = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign wr      = access && wb_we_i;
    assign wr_lo   = wr && wb_sel_i[0];
    assign wr_hi   = wr && wb_sel_i[1];
    assign sel_ch3 = (wb_adr_i == `ADR_CH3);
    assign sel_ch4 = (wb_adr_i == `ADR_CH4);
    assign sel_bk  = (wb_adr_i == `ADR_BKDT);
    assign bk_wr_hi = wr_hi && sel_bk;
    assign bk_wr_lo = wr_lo && sel_bk;

    // polarity 0 means low level active; clock failure needs no polarity
    assign brk_raw = st_q.en_eff &&
        ((break_pin_i == st_q.pol_eff) || clock_security_fail_i);

    // byte-lane merge into the current value image
    generate
        for (genvar i = 0; i < 2; i++) begin : g_ch
            assign wmerge[i] = {
                wb_sel_i[1] ? wb_dat_i[15:8] : ch_value[i][15:8],
                wb_sel_i[0] ? wb_dat_i[7:0]  : ch_value[i][7:0]};
            assign ch_ctl[i] = '{
                is_input: ch_is_input_i[i],
                preload:  ch_preload_en_i[i],
                update:   update_evt_i,
                capture:  ch_capture_event_i[i],
                wr:       wr && (wb_sel_i[1:0] != 2'b00) &&
                          (i == 0 ? sel_ch3 : sel_ch4),
                wdata:    wmerge[i],
                cnt:      timer_counter_value_i};
            ch34_value_unit u_unit (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .ctl_i   (ch_ctl[i]),
                .value_o (ch_value[i]),
                .cmp_o   (ch_cmp[i])
            );
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        ce   = 1'b0;
        cn   = 1'b0;
        off_en = 1'b0;

        // bus answer: one-cycle ack, unmapped reads give zero
        st_d.ack = access;
        if (access && !wb_we_i) begin
            if (sel_ch3) begin
                st_d.rdat = {16'h0000, ch_value[0]};
            end else if (sel_ch4) begin
                st_d.rdat = {16'h0000, ch_value[1]};
            end else if (sel_bk) begin
                st_d.rdat = {16'h0000, st_q.bk};
            end else begin
                st_d.rdat = 32'h0000_0000;
            end
        end

        // low byte: dead-time setting, protected from lock level 1
        if (bk_wr_lo && st_q.bk.lock_level == 2'b00) begin
            st_d.bk.deadtime_setting = wb_dat_i[`BK_DT_HI:`BK_DT_LO];
        end

        // high byte: protected fields by lock level
        if (bk_wr_hi) begin
            if (st_q.bk.lock_level == 2'b00) begin
                st_d.bk.aoe    = wb_dat_i[`BK_AOE];
                st_d.bk.pol    = wb_dat_i[`BK_POL];
                st_d.bk.brk_en = wb_dat_i[`BK_EN];
            end
            if (st_q.bk.lock_level < 2'b10) begin
                st_d.bk.run_offstate_sel = HAS_COMPL && wb_dat_i[`BK_RUN_OFFSTATE_SEL];
                st_d.bk.idle_offstate_sel = wb_dat_i[`BK_IDLE_OFFSTATE_SEL];
            end
            if (!st_q.lock_done) begin
                st_d.bk.lock_level = wb_dat_i[`BK_LCK_HI:`BK_LCK_LO];
                st_d.lock_done     = 1'b1;
            end
            st_d.bk.moe = wb_dat_i[`BK_MOE];
        end

        // automatic re-enable at update, break wins over any set
        if (st_q.bk.aoe && update_evt_i && !brk_raw) begin
            st_d.bk.moe = 1'b1;
        end
        if (brk_raw) begin
            st_d.bk.moe = 1'b0;
        end
        st_d.break_pin = brk_raw;

        // new polarity and enable reach the break path one cycle later
        st_d.pol_eff = st_q.bk.pol;
        st_d.en_eff  = st_q.bk.brk_en;

        // per-channel output gating
        for (int i = 0; i < 2; i++) begin
            ce = channel_out_en_i[i];
            cn = channel_compl_out_en_i[i] && HAS_COMPL;
            off_en = ce || cn;
            if (ch_is_input_i[i]) begin
                st_d.oc_en[i]  = 1'b0;
                st_d.ocn_en[i] = 1'b0;
                st_d.oc[i]     = 1'b0;
            end else if (st_d.bk.moe) begin
                st_d.oc_en[i]  = ce || (st_d.bk.run_offstate_sel && off_en);
                st_d.ocn_en[i] = cn || (st_d.bk.run_offstate_sel && off_en);
                st_d.oc[i]     = ce && ch_cmp[i];
            end else begin
                st_d.oc_en[i]  = st_d.bk.idle_offstate_sel && off_en;
                st_d.ocn_en[i] = st_d.bk.idle_offstate_sel && cn;
                st_d.oc[i]     = 1'b0;
            end
        end

        // dead time in units of the dead-time tick
        casez (st_q.bk.deadtime_setting[7:5])
            3'b0??: st_d.dt_ticks = {2'b00, st_q.bk.deadtime_setting};
            3'b10?: st_d.dt_ticks = {2'b00, 1'b1,
                        st_q.bk.deadtime_setting[5:0], 1'b0};
            3'b110: st_d.dt_ticks = {2'b01,
                        st_q.bk.deadtime_setting[4:0], 3'b000};
            default: st_d.dt_ticks = {1'b1,
                        st_q.bk.deadtime_setting[4:0], 4'h0};
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '{bk: `BKDT_RESET, pol_eff: 1'b0, en_eff: 1'b0,
                      lock_done: 1'b0, ack: 1'b0, rdat: 32'h0000_0000,
                      oc: 2'b00, oc_en: 2'b00, ocn_en: 2'b00,
                      break_pin: 1'b0, dt_ticks: 10'h000};
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_ack_o         = st_q.ack;
    assign wb_dat_o         = st_q.rdat;
    assign ch_compare_out_o = st_q.oc;
    assign out_en_o         = st_q.oc_en;
    assign compl_out_en_o   = st_q.ocn_en;
    assign main_output_en_o = st_q.bk.moe;
    assign break_active_o   = st_q.break_pin;
    assign deadtime_ticks_o = st_q.dt_ticks;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_break_clears_moe: assert property (
        brk_raw |=> !main_output_en_o && break_active_o)
        else $error("break did not clear main output enable");
    a_break_pin_level: assert property (
        st_q.en_eff && !clock_security_fail_i
        |-> brk_raw == (break_pin_i == st_q.pol_eff))
        else $error("break level decode wrong");
    a_break_disabled: assert property (
        !st_q.en_eff |=> !break_active_o)
        else $error("break acted while disabled");
    a_cfg_delay: assert property (
        bk_wr_hi && st_q.bk.lock_level == 2'b00
        |=> st_q.bk.brk_en == $past(wb_dat_i[`BK_EN]) ##1
            st_q.en_eff == $past(wb_dat_i[`BK_EN], 2) &&
            st_q.pol_eff == $past(wb_dat_i[`BK_POL], 2))
        else $error("break enable not applied one cycle late");
    a_auto_set: assert property (
        st_q.bk.aoe && update_evt_i && !brk_raw |=> main_output_en_o)
        else $error("auto enable did not set main enable");
    a_no_auto_set: assert property (
        !st_q.bk.aoe && !main_output_en_o && !bk_wr_hi
        |=> !main_output_en_o)
        else $error("main enable set without software");
    a_gate_outputs: assert property (
        ch_compare_out_o != 2'b00 |-> main_output_en_o)
        else $error("compare output active with main enable low");
    a_idle_offstate: assert property (
        !st_d.bk.moe && !st_d.bk.idle_offstate_sel |=> out_en_o == 2'b00)
        else $error("output enabled in idle with off-state clear");
    a_lock_once: assert property (
        st_q.lock_done |=> $stable(st_q.bk.lock_level))
        else $error("lock level changed after first write");
    a_no_run_off: assert property (
        !HAS_COMPL |-> !st_q.bk.run_offstate_sel)
        else $error("run off-state bit present without complements");
    a_dt_linear: assert property (
        !st_q.bk.deadtime_setting[7]
        |=> deadtime_ticks_o == {2'b00, $past(st_q.bk.deadtime_setting)})
        else $error("linear dead time wrong");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_break: cover property (main_output_en_o ##1 break_active_o);
    c_auto: cover property (!main_output_en_o ##1 main_output_en_o
                            && st_q.bk.aoe);
    c_lock: cover property (bk_wr_hi && st_q.lock_done);

endmodule : timer_ch34_break

// [testbench/timer_ch34_far_side.sv]
// Purpose: far side of the break input: the pin that trips the power stage
// Assumes: the pin is pulled toward its inactive level when not tripping
// Notes:   pin changes just after a clock edge, as a synchronised input
module timer_ch34_far_side (
    // clock
    input  wire logic clk_i,
    // bench controls
    input  wire logic trip_i,
    input  wire logic active_high_i,
    // break pin toward the timer
    output logic      break_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // released pin rests at the inactive level for the chosen polarity
    always @(posedge clk_i) begin
        break_pin_o <= trip_i ? active_high_i : ~active_high_i;
    end
endmodule : timer_ch34_far_side

// [testbench/timer_ch34_compare_and_break_ctrl_tb_top.sv]
// Purpose: self-checking bench for channel 3/4 values and break control
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   a register model tracks every write and predicts all outputs
module timer_ch34_compare_and_break_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] timer_counter_value_i, v, m_bk, m_val[2], m_act[2];
    logic [1:0]  ch_is_input_i, ch_preload_en_i, ch_capture_event_i;
    logic [1:0]  channel_out_en_i, channel_compl_out_en_i;
    logic [1:0]  ch_compare_out_o, out_en_o, compl_out_en_o;
    logic        update_evt_i, clock_security_fail_i, break_pin_i;
    logic        main_output_en_o, break_active_o, trip, trip_high, m_done;
    logic [9:0]  deadtime_ticks_o;
    int          failures, checked;
    logic [7:0]  dt_list [5] = '{8'h45, 8'h9b, 8'hc7, 8'hf3, 8'h7f};

    timer_ch34_break #(.HAS_COMPL(1'b1)) timer_ch34_break_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .timer_counter_value_i(timer_counter_value_i),
        .update_evt_i(update_evt_i), .ch_is_input_i(ch_is_input_i),
        .ch_preload_en_i(ch_preload_en_i),
        .ch_capture_event_i(ch_capture_event_i),
        .channel_out_en_i(channel_out_en_i),
        .channel_compl_out_en_i(channel_compl_out_en_i),
        .break_pin_i(break_pin_i),
        .clock_security_fail_i(clock_security_fail_i),
        .ch_compare_out_o(ch_compare_out_o), .out_en_o(out_en_o),
        .compl_out_en_o(compl_out_en_o),
        .main_output_en_o(main_output_en_o),
        .break_active_o(break_active_o), .deadtime_ticks_o(deadtime_ticks_o)
    );

    timer_ch34_far_side timer_ch34_far_side_i (
        .clk_i(clk_i), .trip_i(trip), .active_high_i(trip_high),
        .break_pin_o(break_pin_i)
    );

    always #50 clk_i = ~clk_i;

    task automatic summarize;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [3:0] s, input logic [15:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("MISMATCH t=%0t no bus answer", $time);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    function automatic logic brk_exp();
        return m_bk[12] & ((break_pin_i == m_bk[13]) | clock_security_fail_i);
    endfunction : brk_exp

    function automatic logic [9:0] dt_of(input logic [7:0] d);
        if (!d[7]) return {2'b0, d};
        if (!d[6]) return (10'd64 + 10'(d[5:0])) * 10'd2;
        if (!d[5]) return (10'd32 + 10'(d[4:0])) * 10'd8;
        return (10'd32 + 10'(d[4:0])) * 10'd16;
    endfunction : dt_of

    // model side of a write: lanes, input-mode refusal, lock protection
    task automatic wr(input logic [7:0] a, input logic [3:0] s,
                      input logic [15:0] d);
        logic [15:0] m;
        int          c;
        m = {{8{s[1]}}, {8{s[0]}}};
        c = (a == 8'h40) ? 1 : 0;
        wb(1'b1, a, s, d);
        if (a == 8'h44) begin
            if (m_bk[9:8] >= 2'd1) m &= 16'h8f00;
            if (m_bk[9:8] >= 2'd2) m &= 16'h8300;
            if (m_done) m &= 16'hfcff;
            m_done |= s[1];
            m_bk = (m_bk & ~m) | (d & m);
        end else if ((a == 8'h3c || a == 8'h40) && !ch_is_input_i[c]) begin
            m_val[c] = (m_val[c] & ~m) | (d & m);
            if (!ch_preload_en_i[c]) m_act[c] = m_val[c];
        end
    endtask : wr

    task automatic chk_rd(input logic [7:0] a);
        wb(1'b0, a, 4'hf, 16'h0);
        v = (a == 8'h44) ? m_bk : (a == 8'h3c) ? m_val[0] :
            (a == 8'h40) ? m_val[1] : 16'h0;
        cmp(rd[31:16], 16'h0);
        cmp(rd[15:0], v);
    endtask : chk_rd

    task automatic upd_pulse;
        @(posedge clk_i);
        update_evt_i <= 1'b1;
        @(posedge clk_i);
        update_evt_i <= 1'b0;
        for (int k = 0; k < 2; k++) if (ch_preload_en_i[k]) m_act[k] = m_val[k];
        if (m_bk[14] && !brk_exp()) m_bk[15] = 1'b1;
    endtask : upd_pulse

    task automatic chk_out;
        logic [1:0] oe, ne, co, ce, cn;
        logic       r;
        repeat (4) @(posedge clk_i);
        if (brk_exp()) m_bk[15] = 1'b0;
        ce = channel_out_en_i;
        cn = channel_compl_out_en_i;
        for (int k = 0; k < 2; k++) begin
            r = ce[k] | cn[k];
            oe[k] = m_bk[15] ? ce[k] | (m_bk[11] & r) : m_bk[10] & r;
            ne[k] = m_bk[15] ? cn[k] | (m_bk[11] & r) : m_bk[10] & cn[k];
            co[k] = ce[k] & m_bk[15] & (timer_counter_value_i < m_act[k]);
            if (ch_is_input_i[k]) {oe[k], ne[k], co[k]} = 3'b000;
        end
        cmp({14'h0, ch_compare_out_o}, {14'h0, co});
        cmp({14'h0, out_en_o}, {14'h0, oe});
        cmp({14'h0, compl_out_en_o}, {14'h0, ne});
        cmp({15'h0, main_output_en_o}, {15'h0, m_bk[15]});
        cmp({15'h0, break_active_o}, {15'h0, brk_exp()});
        cmp({6'h0, deadtime_ticks_o}, {6'h0, dt_of(m_bk[7:0])});
    endtask : chk_out

    task automatic mreset;
        m_bk = 16'h0;
        m_done = 1'b0;
        for (int k = 0; k < 2; k++) begin
            m_val[k] = 16'h0;
            m_act[k] = 16'h0;
        end
    endtask : mreset

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        summarize();
    end

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, update_evt_i} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, timer_counter_value_i} = '0;
        {ch_is_input_i, ch_preload_en_i, ch_capture_event_i} = 6'h0;
        {channel_out_en_i, channel_compl_out_en_i} = 4'h0;
        {clock_security_fail_i, trip, trip_high} = 3'b001;
        {failures, checked} = 0;
        mreset();
        void'($urandom(76));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 8'h3c; a <= 8'h48; a += 4) chk_rd(8'(a));
        wr(8'h48, 4'h3, 16'hffff);
        chk_rd(8'h48);
        wr(8'h44, 4'h3, 16'hb010);
        chk_out;
        foreach (dt_list[i]) begin
            wr(8'h44, 4'h1, {8'h0, dt_list[i]});
            chk_out;
        end
        channel_out_en_i <= 2'b11;
        channel_compl_out_en_i <= 2'b01;
        for (int c = 0; c < 2; c++) begin
            wr(c ? 8'h40 : 8'h3c, 4'h3, 16'($urandom));
            timer_counter_value_i <= 16'($urandom);
            chk_out;
            chk_rd(c ? 8'h40 : 8'h3c);
        end
        wr(8'h40, 4'h3, 16'h8000);
        ch_preload_en_i <= 2'b10;
        timer_counter_value_i <= 16'h4000;
        wr(8'h40, 4'h3, 16'h1000);
        chk_out;
        chk_rd(8'h40);
        upd_pulse();
        chk_out;
        for (int k = 0; k < 8; k++) begin
            channel_out_en_i <= 2'($urandom);
            channel_compl_out_en_i <= 2'($urandom);
            wr(8'h44, 4'h2, {k[0], 3'b011, k[1], k[2], 10'h0});
            chk_out;
        end
        wr(8'h44, 4'h2, 16'h3300);
        chk_rd(8'h44);
        for (int p = 1; p >= 0; p--) begin
            wr(8'h44, 4'h2, {2'b10, p[0], 13'h0});
            trip_high <= p[0];
            @(posedge clk_i);
            trip <= 1'b1;
            chk_out;
            trip <= 1'b0;
            repeat (2) @(posedge clk_i);
            wr(8'h44, 4'h2, {2'b10, p[0], 13'h1000});
            chk_out;
            trip <= 1'b1;
            chk_out;
            trip <= 1'b0;
        end
        wr(8'h44, 4'h2, 16'h9000);
        clock_security_fail_i <= 1'b1;
        chk_out;
        clock_security_fail_i <= 1'b0;
        upd_pulse();
        chk_out;
        wr(8'h44, 4'h2, 16'h5000);
        clock_security_fail_i <= 1'b1;
        upd_pulse();
        chk_out;
        clock_security_fail_i <= 1'b0;
        upd_pulse();
        chk_out;
        ch_is_input_i <= 2'b01;
        channel_out_en_i <= 2'b10;
        wr(8'h3c, 4'h3, 16'h5a5a);
        timer_counter_value_i <= 16'($urandom);
        ch_capture_event_i <= 2'b01;
        @(posedge clk_i);
        ch_capture_event_i <= 2'b00;
        m_val[0] = timer_counter_value_i;
        chk_rd(8'h3c);
        chk_out;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        mreset();
        wr(8'h44, 4'h3, 16'h0e22);
        wr(8'h44, 4'h3, 16'hf1ff);
        chk_rd(8'h44);
        chk_out;
        summarize();
    end
endmodule : timer_ch34_compare_and_break_ctrl_tb_top
